/* design/tidc_map.svh */
// Offsets, field positions, reset values and timing counts for the trip indicator display controller.
// Assumes pclk at 50 MHz; included by bare name.
`ifndef TIDC_MAP_SVH
`define TIDC_MAP_SVH
`define TIDC_CLK_HZ 50000000
`define TIDC_HEART_HALF_MS 500
`define TIDC_HEART_HALF_CYC ((`TIDC_CLK_HZ / 1000) * `TIDC_HEART_HALF_MS)
`define TIDC_HILOAD_S 40
`define TIDC_HILOAD_CYC (`TIDC_CLK_HZ * `TIDC_HILOAD_S)
`define TIDC_DEBOUNCE_MS 10
`define TIDC_DEBOUNCE_CYC ((`TIDC_CLK_HZ / 1000) * `TIDC_DEBOUNCE_MS)
`define TIDC_HILOAD_PCT 85
`define TIDC_OVR_DEF 16'h2000
// APB register byte offsets
`define TIDC_REG_CTRL 12'h000
`define TIDC_REG_LDPU 12'h004
`define TIDC_REG_STAT 12'h008
`define TIDC_REG_DISP 12'h00c
`define TIDC_REG_TRIPI 12'h010
`define TIDC_REG_OVR 12'h014
// CTRL fields
`define TIDC_CTRL_GND 0
`define TIDC_CTRL_RST 1
`define TIDC_CTRL_INST 2
`define TIDC_CTRL_BRKCL 3
`define TIDC_LDPU_RST 16'h0100
`endif

/* design/tidc_pkg.sv */
// Types for the trip indicator display controller.
// Included before the main module; constants live in tidc_map.svh.
package tidc_pkg;
  typedef enum logic [1:0] {
    TIDC_SEL_A = 2'b00,
    TIDC_SEL_B = 2'b01,
    TIDC_SEL_C = 2'b10,
    TIDC_SEL_G = 2'b11
  } tidc_sel_e;
  typedef enum logic [1:0] {
    TIDC_DSP_AMM = 2'b00,
    TIDC_DSP_MSG = 2'b01,
    TIDC_DSP_TRIPI = 2'b10,
    TIDC_DSP_TEST = 2'b11
  } tidc_dsp_e;
  typedef enum logic [2:0] {
    TIDC_CAUSE_NONE = 3'b000,
    TIDC_CAUSE_INST = 3'b001,
    TIDC_CAUSE_SD = 3'b010,
    TIDC_CAUSE_LD = 3'b011,
    TIDC_CAUSE_GND = 3'b100,
    TIDC_CAUSE_OVR = 3'b101
  } tidc_cause_e;
endpackage

/* design/tidc_ctrl.sv */
// Trip indicator and display controller: lamps, high-load alarm, ammeter and trip message display.
// Assumes synchronous inputs on pclk, current values from protection logic, APB master for settings.
// Functional notes
// - Status lamp toggles on and off with one second period.
// - High-load detected when load current reaches 85% of long delay pickup.
// - High-load lamp and relay turn on only after 40 seconds persistent high load.
// - Automatic trip latches the lamp of the causing protection mode.
// - Trip lamps stay latched across control power loss until trip reset.
// - Battery check lamp shows battery status while battery test button held.
// - Display has four alphanumeric character positions for readings and messages.
// - Breaker closed in normal service shows selected phase or ground current in kA.
// - Exactly one pointer lamp marks which current is shown.
// - Each step press advances to the next available current reading.
// - Ground reading and pointer exist only with ground fault protection configured.
// - Shown reading stays selected until operator changes it.
// - After automatic trip with power, display shows coded trip cause message.
// - Trip message stays latched until step press, ignoring other updates; code also ends it on a trip reset.
// - After releasing press, display shows current captured at trip initiation; code switches on the debounced press edge, not the release.
// - Trip history and lamp states retained while control power present.
// - Variants without adjustable instantaneous get fixed high override trip threshold.
// - Short time and ground functions each get own zone interlock in/out pair.
// - Test message shown while test button held, only for full trip test.
//
// The APB register port and the register addresses are this design's own decisions.
`include "tidc_map.svh"

module tidc_ctrl #(
  parameter int HEART_HALF_CYC = `TIDC_HEART_HALF_CYC,
  parameter longint HILOAD_CYC = `TIDC_HILOAD_CYC,
  parameter int DEBOUNCE_CYC = `TIDC_DEBOUNCE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ctrl_power_ok,
  input wire logic [15:0] cur_a,
  input wire logic [15:0] cur_b,
  input wire logic [15:0] cur_c,
  input wire logic [15:0] cur_g,
  input wire logic trip_inst,
  input wire logic trip_short,
  input wire logic trip_long,
  input wire logic trip_gnd,
  input wire logic step_btn,
  input wire logic batt_btn,
  input wire logic batt_good,
  input wire logic test_btn,
  input wire logic test_full_trip,
  input wire logic trip_reset_btn,
  input wire logic zsi_sd_in,
  input wire logic zsi_gnd_in,
  input wire logic zsi_sd_req,
  input wire logic zsi_gnd_req,
  output logic zsi_sd_out,
  output logic zsi_gnd_out,
  output logic zsi_sd_restrained,
  output logic zsi_gnd_restrained,
  output logic override_trip,
  output logic status_lamp,
  output logic hiload_lamp,
  output logic hiload_relay,
  output logic [3:0] cause_lamps,
  output logic batt_lamp,
  output logic [3:0] pointer_lamps,
  output logic [31:0] disp_chars
);

  // Character codes, ASCII
  // Unknown cause codes show blanks rather than a stale message
  function automatic logic [31:0] msg_of(input tidc_pkg::tidc_cause_e c);
    case (c)
      tidc_pkg::TIDC_CAUSE_INST: msg_of = 32'h494e5354;
      tidc_pkg::TIDC_CAUSE_SD: msg_of = 32'h20534454;
      tidc_pkg::TIDC_CAUSE_LD: msg_of = 32'h204c4454;
      tidc_pkg::TIDC_CAUSE_GND: msg_of = 32'h474e4454;
      tidc_pkg::TIDC_CAUSE_OVR: msg_of = 32'h4f524944;
      default: msg_of = 32'h20202020;
    endcase
  endfunction

  // Binary kA value (tenths) shown as four hex digit characters
  function automatic logic [31:0] num_chars(input logic [15:0] v);
    logic [31:0] r;
    logic [3:0] n;
    r = 32'h0;
    for (int i = 0; i < 4; i++) begin
      n = v[i*4 +: 4];
      r[i*8 +: 8] = (n < 4'ha) ? {4'h3, n} : (8'h37 + {4'h0, n});
    end
    return r;
  endfunction

  // Debounce filter: counts samples that disagree with the filtered level
  // Any agreeing sample restarts the count, so a bounce never reaches the end
  function automatic logic [23:0] cnt_next(input logic same, input logic [23:0] c);
    return same ? 24'h0 : ((c == 24'(DEBOUNCE_CYC)) ? c : c + 24'h1);
  endfunction

  // Software settings
  logic ctrl_gnd_ff;
  logic ctrl_inst_ff;
  logic brk_closed_ff;
  logic [15:0] ldpu_ff;
  logic [15:0] ovr_ff;

  // Pushbutton filters and edge detectors
  logic [23:0] step_cnt_ff;
  logic [23:0] rst_cnt_ff;
  logic step_db_ff;
  logic rst_db_ff;
  logic step_prev_ff;
  logic rst_prev_ff;
  logic step_evt;
  logic rst_evt;

  // Heartbeat and high-load alarm
  logic [25:0] heart_cnt_ff;
  logic [31:0] hl_cnt_ff;
  logic hl_cond;
  logic [31:0] load_max;
  logic [15:0] cur_max;

  // Display selection and trip latch
  tidc_pkg::tidc_sel_e sel_ff;
  tidc_pkg::tidc_sel_e nxt_sel;
  tidc_pkg::tidc_dsp_e dsp_ff;
  tidc_pkg::tidc_cause_e cause_ff;
  logic [15:0] trip_cur_ff;
  logic new_trip;
  logic sw_reset;
  logic [15:0] sel_cur;

  // APB: zero wait states, every address answers; unmapped reads zero
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_gnd_ff <= 1'b0;
      ctrl_inst_ff <= 1'b0;
      brk_closed_ff <= 1'b0;
      ldpu_ff <= `TIDC_LDPU_RST;
      ovr_ff <= `TIDC_OVR_DEF;
    end else if (psel && penable && pwrite) begin
      case (paddr)
        `TIDC_REG_CTRL: begin
          ctrl_gnd_ff <= pwdata[`TIDC_CTRL_GND];
          ctrl_inst_ff <= pwdata[`TIDC_CTRL_INST];
          brk_closed_ff <= pwdata[`TIDC_CTRL_BRKCL];
        end
        `TIDC_REG_LDPU: ldpu_ff <= pwdata[15:0];
        `TIDC_REG_OVR: ovr_ff <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  assign sw_reset = psel && penable && pwrite && (paddr == `TIDC_REG_CTRL) && pwdata[`TIDC_CTRL_RST];

  // Read mux registered on setup so prdata is a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `TIDC_REG_CTRL: prdata <= {28'h0, brk_closed_ff, ctrl_inst_ff, 1'b0, ctrl_gnd_ff};
        `TIDC_REG_LDPU: prdata <= {16'h0, ldpu_ff};
        // Status word: cause, display mode, selection, alarm and heartbeat
        `TIDC_REG_STAT: prdata <= {22'h0, cause_ff, dsp_ff, sel_ff, hiload_lamp, hl_cond, status_lamp};
        `TIDC_REG_DISP: prdata <= disp_chars;
        `TIDC_REG_TRIPI: prdata <= {16'h0, trip_cur_ff};
        `TIDC_REG_OVR: prdata <= {16'h0, ovr_ff};
        default: prdata <= 32'h0;
      endcase
    end
  end

  // Pushbutton debounce; mechanical bounce would otherwise give several steps per press
  // Filtered level moves only after DEBOUNCE_CYC disagreeing samples in a row
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_cnt_ff <= 24'h0;
      rst_cnt_ff <= 24'h0;
      step_db_ff <= 1'b0;
      rst_db_ff <= 1'b0;
      step_prev_ff <= 1'b0;
      rst_prev_ff <= 1'b0;
    end else begin
      step_cnt_ff <= cnt_next(step_btn == step_db_ff, step_cnt_ff);
      rst_cnt_ff <= cnt_next(trip_reset_btn == rst_db_ff, rst_cnt_ff);
      if (step_cnt_ff == 24'(DEBOUNCE_CYC) - 24'h1 && step_btn != step_db_ff) step_db_ff <= step_btn;
      if (rst_cnt_ff == 24'(DEBOUNCE_CYC) - 24'h1 && trip_reset_btn != rst_db_ff) rst_db_ff <= trip_reset_btn;
      step_prev_ff <= step_db_ff;
      rst_prev_ff <= rst_db_ff;
    end
  end
  assign step_evt = step_db_ff && !step_prev_ff;
  assign rst_evt = (rst_db_ff && !rst_prev_ff) || sw_reset;

  // Heartbeat: toggles each half second while control power is present
  // Power loss restarts the phase, so the first beat after return is a full half period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      heart_cnt_ff <= 26'h0;
      status_lamp <= 1'b0;
    end else if (!ctrl_power_ok) begin
      heart_cnt_ff <= 26'h0;
      status_lamp <= 1'b0;
    end else if (heart_cnt_ff == 26'(HEART_HALF_CYC - 1)) begin
      heart_cnt_ff <= 26'h0;
      status_lamp <= !status_lamp;
    end else begin
      heart_cnt_ff <= heart_cnt_ff + 26'h1;
    end
  end

  // High load: max phase *100 >= pickup *85, integer-exact
  // Count holds at its end so the alarm stays on while the load lasts
  assign cur_max = (cur_a > cur_b) ? ((cur_a > cur_c) ? cur_a : cur_c) : ((cur_b > cur_c) ? cur_b : cur_c);
  assign load_max = 32'(cur_max) * 32'd100;
  assign hl_cond = load_max >= 32'(ldpu_ff) * 32'(`TIDC_HILOAD_PCT);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hl_cnt_ff <= 32'h0;
      hiload_lamp <= 1'b0;
      hiload_relay <= 1'b0;
    end else if (!hl_cond) begin
      hl_cnt_ff <= 32'h0;
      hiload_lamp <= 1'b0;
      hiload_relay <= 1'b0;
    end else if (hl_cnt_ff == 32'(HILOAD_CYC - 1)) begin
      hiload_lamp <= 1'b1;
      hiload_relay <= 1'b1;
    end else begin
      hl_cnt_ff <= hl_cnt_ff + 32'h1;
    end
  end

  // Fixed override threshold when no adjustable instantaneous exists
  // The threshold register stands in for the per-rating constant, loaded once at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) override_trip <= 1'b0;
    else override_trip <= !ctrl_inst_ff && (cur_max >= ovr_ff);
  end

  // Zone interlock: separate pair each for short time and ground
  // Ground pair stays quiet when ground protection is not fitted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zsi_sd_out <= 1'b0;
      zsi_gnd_out <= 1'b0;
      zsi_sd_restrained <= 1'b0;
      zsi_gnd_restrained <= 1'b0;
    end else begin
      zsi_sd_out <= zsi_sd_req || zsi_sd_in;
      zsi_gnd_out <= ctrl_gnd_ff && (zsi_gnd_req || zsi_gnd_in);
      zsi_sd_restrained <= zsi_sd_in;
      zsi_gnd_restrained <= ctrl_gnd_ff && zsi_gnd_in;
    end
  end

  // Trip latch; held until reset, battery supplies it when control power drops
  // Ground current is captured when no inst, short or long trip joins the ground trip, else the largest phase
  assign new_trip = (cause_ff == tidc_pkg::TIDC_CAUSE_NONE) &&
                    (trip_inst || trip_short || trip_long || (trip_gnd && ctrl_gnd_ff) || override_trip);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_ff <= tidc_pkg::TIDC_CAUSE_NONE;
      cause_lamps <= 4'h0;
      trip_cur_ff <= 16'h0;
    end else if (new_trip) begin // Trip wins over a simultaneous reset
      if (override_trip) cause_ff <= tidc_pkg::TIDC_CAUSE_OVR;
      else if (trip_inst) cause_ff <= tidc_pkg::TIDC_CAUSE_INST;
      else if (trip_short) cause_ff <= tidc_pkg::TIDC_CAUSE_SD;
      else if (trip_long) cause_ff <= tidc_pkg::TIDC_CAUSE_LD;
      else cause_ff <= tidc_pkg::TIDC_CAUSE_GND;
      cause_lamps <= {trip_gnd && ctrl_gnd_ff, trip_long, trip_short, trip_inst || override_trip};
      trip_cur_ff <= (trip_gnd && ctrl_gnd_ff && !trip_inst && !trip_short && !trip_long) ? cur_g : cur_max;
    end else if (rst_evt) begin
      cause_ff <= tidc_pkg::TIDC_CAUSE_NONE;
      cause_lamps <= 4'h0;
    end
    // Power loss does not clear the latch
  end

  // Battery lamp only while its test button held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) batt_lamp <= 1'b0;
    else batt_lamp <= batt_btn && batt_good;
  end

  // Selection stepping, skipping ground when not configured
  // A pointer left on ground is pulled back to phase A when ground is removed
  always_comb begin
    case (sel_ff)
      tidc_pkg::TIDC_SEL_A: nxt_sel = tidc_pkg::TIDC_SEL_B;
      tidc_pkg::TIDC_SEL_B: nxt_sel = tidc_pkg::TIDC_SEL_C;
      tidc_pkg::TIDC_SEL_C: nxt_sel = ctrl_gnd_ff ? tidc_pkg::TIDC_SEL_G : tidc_pkg::TIDC_SEL_A;
      tidc_pkg::TIDC_SEL_G: nxt_sel = tidc_pkg::TIDC_SEL_A;
      default: nxt_sel = tidc_pkg::TIDC_SEL_A;
    endcase
  end

  // Display mode; message locks until step, then shows captured trip current
  // A trip outranks the test message; reset returns to the ammeter from message or trip current, not from test
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dsp_ff <= tidc_pkg::TIDC_DSP_AMM;
      sel_ff <= tidc_pkg::TIDC_SEL_A;
    end else begin
      if (!ctrl_gnd_ff && sel_ff == tidc_pkg::TIDC_SEL_G) sel_ff <= tidc_pkg::TIDC_SEL_A;
      case (dsp_ff)
        tidc_pkg::TIDC_DSP_AMM: begin
          if (new_trip && ctrl_power_ok) dsp_ff <= tidc_pkg::TIDC_DSP_MSG;
          else if (test_btn && test_full_trip) dsp_ff <= tidc_pkg::TIDC_DSP_TEST;
          else if (step_evt) sel_ff <= nxt_sel;
        end
        tidc_pkg::TIDC_DSP_MSG: begin
          if (rst_evt) dsp_ff <= tidc_pkg::TIDC_DSP_AMM;
          else if (step_evt) dsp_ff <= tidc_pkg::TIDC_DSP_TRIPI;
        end
        tidc_pkg::TIDC_DSP_TRIPI: begin
          if (rst_evt || step_evt) dsp_ff <= tidc_pkg::TIDC_DSP_AMM;
        end
        tidc_pkg::TIDC_DSP_TEST: begin
          if (new_trip && ctrl_power_ok) dsp_ff <= tidc_pkg::TIDC_DSP_MSG;
          else if (!(test_btn && test_full_trip)) dsp_ff <= tidc_pkg::TIDC_DSP_AMM;
        end
        default: dsp_ff <= tidc_pkg::TIDC_DSP_AMM;
      endcase
    end
  end

  // Current value behind the present selection
  always_comb begin
    case (sel_ff)
      tidc_pkg::TIDC_SEL_A: sel_cur = cur_a;
      tidc_pkg::TIDC_SEL_B: sel_cur = cur_b;
      tidc_pkg::TIDC_SEL_C: sel_cur = cur_c;
      default: sel_cur = cur_g;
    endcase
  end

  // Four characters and one-hot pointer, ammeter reading blank while breaker open
  // Pointer stays dark outside the ammeter so it never marks a message
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp_chars <= 32'h20202020;
      pointer_lamps <= 4'h0;
    end else begin
      pointer_lamps <= 4'h0;
      case (dsp_ff)
        tidc_pkg::TIDC_DSP_MSG: disp_chars <= msg_of(cause_ff);
        tidc_pkg::TIDC_DSP_TRIPI: disp_chars <= num_chars(trip_cur_ff);
        tidc_pkg::TIDC_DSP_TEST: disp_chars <= 32'h54455354;
        default: begin
          if (brk_closed_ff && ctrl_power_ok) begin
            disp_chars <= num_chars(sel_cur);
            pointer_lamps <= 4'h1 << sel_ff;
          end else begin
            disp_chars <= 32'h20202020;
          end
        end
      endcase
    end
  end

endmodule

/* sim/tidc_ctrl_props.sv */
// Checker for the lamp and display outputs of the trip indicator controller.
// Assumes one clock domain; bound to every tidc_ctrl instance.
module tidc_ctrl_props #(
  parameter int HEART_HALF_CYC = 10,
  parameter int DEBOUNCE_CYC = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ctrl_power_ok,
  input wire logic trip_inst,
  input wire logic trip_short,
  input wire logic trip_long,
  input wire logic trip_gnd,
  input wire logic step_btn,
  input wire logic batt_btn,
  input wire logic batt_good,
  input wire logic status_lamp,
  input wire logic [3:0] cause_lamps,
  input wire logic batt_lamp,
  input wire logic [3:0] pointer_lamps,
  input wire logic [31:0] disp_chars
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // One cause alone, nothing latched, power present
  sequence fresh_s(t);
    cause_lamps == 4'h0 && ctrl_power_ok && t && $onehot({trip_inst, trip_short, trip_long, trip_gnd});
  endsequence
  // Natural fall; a power drop also darkens the lamp and is excluded
  sequence beat_fall_s;
    $fell(status_lamp) && ctrl_power_ok && $past(ctrl_power_ok);
  endsequence
  heart_period_a: assert property (
    beat_fall_s |-> ##(HEART_HALF_CYC - 1) (!status_lamp || !ctrl_power_ok) ##1 (status_lamp || !ctrl_power_ok))
    else $error("heartbeat half period wrong");
  batt_lamp_a: assert property (batt_btn && batt_good |=> batt_lamp)
    else $error("battery lamp not lit");
  cause_hold_a: assert property (
    cause_lamps != 4'h0 |=> cause_lamps == $past(cause_lamps) || cause_lamps == 4'h0)
    else $error("latched cause lamp changed");
  ptr_onehot_a: assert property (
    pointer_lamps != 4'h0 |-> $onehot(pointer_lamps) && $past(ctrl_power_ok))
    else $error("pointer lamps not one-hot");
  step_move_a: assert property (
    $changed(pointer_lamps) && pointer_lamps != 4'h0 && $past(pointer_lamps) != 4'h0
      |-> $past(step_btn, 2) && $past(step_btn, DEBOUNCE_CYC))
    else $error("pointer moved without a held press");
  trip_lamp_a: assert property (fresh_s(trip_short) |=> cause_lamps == 4'b0010)
    else $error("short delay lamp not latched");
  trip_msg_a: assert property (fresh_s(trip_long) |-> ##2 disp_chars == 32'h204c4454)
    else $error("long delay message missing");
  msg_hold_a: assert property (
    disp_chars == 32'h20534454 && cause_lamps != 4'h0 && !step_btn |=> disp_chars == 32'h20534454)
    else $error("trip message left without a press");
endmodule
bind tidc_ctrl tidc_ctrl_props #(.HEART_HALF_CYC(HEART_HALF_CYC), .DEBOUNCE_CYC(DEBOUNCE_CYC))
  tidc_ctrl_props_i (.pclk, .presetn, .ctrl_power_ok, .trip_inst, .trip_short, .trip_long, .trip_gnd,
  .step_btn, .batt_btn, .batt_good, .status_lamp, .cause_lamps, .batt_lamp, .pointer_lamps, .disp_chars);

/* sim/tidc_prot_model.sv */
// Stand-in for the protection logic: one trip cause level per request.
// Assumes one-cycle requests on pclk; slow ones wait four more cycles.
module tidc_prot_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fire,
  input wire logic slow,
  input wire logic [1:0] cause,
  output logic [3:0] trips
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt_ff;
  logic [1:0] cause_ff;
  // Decision countdown; the cause drops as the breaker opens
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 3'h0;
      cause_ff <= 2'h0;
    end else if (fire) begin
      cnt_ff <= slow ? 3'h7 : 3'h3;
      cause_ff <= cause;
    end else if (cnt_ff != 3'h0) begin
      cnt_ff <= cnt_ff - 3'h1;
    end
  end
  // Level held three cycles, bit order {gnd,long,short,inst}
  assign trips = (cnt_ff != 3'h0 && cnt_ff <= 3'h3) ? 4'h1 << cause_ff : 4'h0;
endmodule

/* sim/tb.sv */
// Testbench for the trip indicator controller with a protection stand-in.
// Assumes the shortened counts below and APB answers as the slave gives them.
`include "tidc_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, disp;
  logic pready, pslverr, ovr, st, hl_l, hl_r, batt_l;
  logic pwr = 1'b1, step_btn = 1'b0, trip_reset_btn = 1'b0, batt_btn = 1'b0, batt_good = 1'b0;
  logic test_btn = 1'b0, test_full_trip = 1'b0, fire = 1'b0, slow = 1'b0;
  logic [1:0] cause = 2'h0;
  logic [3:0] zsi = 4'h0, cause_l, ptr, trips;
  wire [3:0] zo;
  logic [15:0] cap, thr;
  logic [15:0] curs [4] = '{default: 16'h0};
  logic [31:0] msgs [4] = '{32'h494e5354, 32'h20534454, 32'h204c4454, 32'h474e4454};
  int failures = 0, samples_checked = 0, j;
  tidc_ctrl #(.HEART_HALF_CYC(10), .HILOAD_CYC(50), .DEBOUNCE_CYC(4)) tidc_ctrl_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ctrl_power_ok(pwr), .cur_a(curs[0]), .cur_b(curs[1]), .cur_c(curs[2]), .cur_g(curs[3]),
    .trip_inst(trips[0]), .trip_short(trips[1]), .trip_long(trips[2]), .trip_gnd(trips[3]),
    .step_btn, .batt_btn, .batt_good, .test_btn, .test_full_trip, .trip_reset_btn,
    .zsi_sd_in(zsi[0]), .zsi_gnd_in(zsi[1]), .zsi_sd_req(zsi[2]), .zsi_gnd_req(zsi[3]),
    .zsi_sd_out(zo[3]), .zsi_gnd_out(zo[2]), .zsi_sd_restrained(zo[1]), .zsi_gnd_restrained(zo[0]),
    .override_trip(ovr), .status_lamp(st), .hiload_lamp(hl_l), .hiload_relay(hl_r),
    .cause_lamps(cause_l), .batt_lamp(batt_l), .pointer_lamps(ptr), .disp_chars(disp));
  tidc_prot_model tidc_prot_model_i (.pclk, .presetn, .fire, .slow, .cause, .trips);
  // 50 MHz clock
  always #10 pclk = ~pclk;
  // Four-state compare so an unknown never matches
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Setup, then access held until pready is seen high at an edge; only the watchdog ends a wait
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Long press, so the debouncer sees a steady level both ways
  task automatic press(input logic rst);
    if (rst) trip_reset_btn <= 1'b1;
    else step_btn <= 1'b1;
    idle(12);
    trip_reset_btn <= 1'b0;
    step_btn <= 1'b0;
    idle(12);
  endtask
  // Four upper-case hex characters, most significant on the left
  function automatic logic [31:0] hexc(input logic [15:0] v);
    logic [7:0] n;
    hexc = 32'h0;
    for (int i = 0; i < 4; i++) begin
      n = {4'h0, v[i*4 +: 4]};
      hexc[i*8 +: 8] = (n < 8'h0a) ? n + 8'h30 : n + 8'h37;
    end
  endfunction
  // Fresh currents below the alarm level, then one trip request
  task automatic trip(input int k);
    for (int i = 0; i < 4; i++) curs[i] <= 16'($urandom_range(199));
    zsi <= 4'($urandom());
    @(posedge pclk);
    cap = curs[0];
    if (curs[1] > cap) cap = curs[1];
    if (curs[2] > cap) cap = curs[2];
    if (k == 3) cap = curs[3];
    fire <= 1'b1;
    cause <= 2'(k);
    slow <= k[0];
    @(posedge pclk);
    fire <= 1'b0;
    idle(12);
  endtask
  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    void'($urandom(32'heb9bdc66));
    for (int i = 0; i < 4; i++) curs[i] = 16'($urandom_range(199));
    idle(4);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(disp, 32'h20202020);
    chk(ptr, 4'h0);
    apb(1'b0, `TIDC_REG_LDPU, 32'h0);
    chk(rd, 32'h100);
    apb(1'b0, `TIDC_REG_OVR, 32'h0);
    chk(rd, 32'h2000);
    apb(1'b0, 12'h040, 32'h0);
    chk(rd, 32'h0);
    chk(pslverr, 1'b0);
    apb(1'b1, `TIDC_REG_CTRL, 32'h0d);
    idle(3);
    chk(ptr, 4'h1);
    chk(disp, hexc(curs[0]));
    for (int f = 1; f >= 0; f--) begin
      test_btn <= 1'b1;
      test_full_trip <= f[0];
      idle(4);
      chk(disp, f ? 32'h54455354 : hexc(curs[0]));
      test_btn <= 1'b0;
      idle(4);
    end
    // Ground configured for four presses, then dropped and skipped
    for (int i = 1; i < 8; i++) begin
      if (i == 5) apb(1'b1, `TIDC_REG_CTRL, 32'h0c);
      j = (i < 5) ? i % 4 : (i - 4) % 3;
      press(1'b0);
      chk(ptr, 4'h1 << j);
      chk(disp, hexc(curs[j]));
    end
    apb(1'b1, `TIDC_REG_CTRL, 32'h0d);
    for (int b = 0; b < 4; b++) begin
      batt_btn <= b[0];
      batt_good <= b[1];
      idle(2);
      chk(batt_l, b == 3);
    end
    // Alarm threshold is the first current reaching 85 percent of pickup
    thr = 16'($urandom_range(512, 256));
    apb(1'b1, `TIDC_REG_LDPU, {16'h0, thr});
    thr = 16'((85 * thr + 99) / 100);
    curs[1] <= thr - 16'h1;
    idle(70);
    chk(hl_l, 1'b0);
    curs[1] <= thr;
    idle(45);
    chk(hl_l, 1'b0);
    idle(15);
    chk({hl_l, hl_r}, 2'b11);
    curs[1] <= thr - 16'h1;
    idle(3);
    chk(hl_l, 1'b0);
    for (int k = 0; k < 4; k++) begin
      trip(k);
      chk(cause_l, 4'h1 << k);
      chk(zo, {zsi[2] | zsi[0], zsi[3] | zsi[1], zsi[0], zsi[1]});
      chk(disp, msgs[k]);
      apb(1'b0, `TIDC_REG_STAT, 32'h0);
      chk(rd & 32'hfffffffe, (32'(k + 1) << 7) | 32'h20);
      curs[0] <= curs[0] + 16'h1;
      idle(4);
      chk(disp, msgs[k]);
      press(1'b0);
      chk(disp, hexc(cap));
      apb(1'b0, `TIDC_REG_TRIPI, 32'h0);
      chk(rd, {16'h0, cap});
      if (k[0]) press(1'b1);
      else apb(1'b1, `TIDC_REG_CTRL, 32'h0f);
      idle(3);
      chk(cause_l, 4'h0);
    end
    pwr <= 1'b0;
    trip(2);
    chk(cause_l, 4'h4);
    chk(disp, 32'h20202020);
    chk({st, ptr}, 5'h0);
    pwr <= 1'b1;
    idle(25);
    chk(cause_l, 4'h4);
    apb(1'b1, `TIDC_REG_CTRL, 32'h0f);
    apb(1'b1, `TIDC_REG_OVR, 32'h100);
    curs[2] <= 16'h100;
    idle(3);
    chk(ovr, 1'b0);
    apb(1'b1, `TIDC_REG_CTRL, 32'h09);
    idle(3);
    chk(ovr, 1'b1);
    conclude();
  end
  // Hang guard, far beyond the several hundred cycles the run needs
  initial begin
    idle(20000);
    failures++;
    conclude();
  end
endmodule
